// >>> slsc_pkg.sv
// package: constants and types for the strap-configured serial line unit
package slsc_pkg;
  localparam int CLK_HZ     = 100_000_000;
  localparam int BAUD_SLOW  = 110;
  localparam int BAUD_FAST  = 300;
  localparam int OVERSAMPLE = 16;
  localparam int DIV_SLOW   = CLK_HZ / (BAUD_SLOW * OVERSAMPLE);
  localparam int DIV_FAST   = CLK_HZ / (BAUD_FAST * OVERSAMPLE);

  // 777560 and 777540 octal as byte addresses on the 18-bit bus
  localparam logic [17:0] BASE_DEFAULT = 18'h3FF70;
  localparam logic [17:0] OWN_BASE     = 18'h3FF60;
  localparam logic [6:0]  ADDR_FIXED   = 7'h7F;
  localparam logic [6:0]  VEC_FIXED_HI = 7'h00;
  localparam logic [2:0]  VEC_FIXED_LO = 3'h0;

  localparam logic [1:0] REG_RX_STAT  = 2'h0;
  localparam logic [1:0] REG_RX_DATA  = 2'h1;
  localparam logic [1:0] REG_TX_STAT  = 2'h2;
  localparam logic [1:0] REG_TX_DATA  = 2'h3;
  localparam logic [1:0] REG_IRQ_STAT = 2'h0;
  localparam logic [1:0] REG_IRQ_MASK = 2'h1;
  localparam logic [1:0] REG_LINE     = 2'h2;

  localparam int RX_DONE_BIT  = 7;
  localparam int TX_READY_BIT = 7;
  localparam int TX_BREAK_BIT = 0;
  localparam int LINE_ACT_BIT = 0;

  localparam int IRQ_RX   = 0;
  localparam int IRQ_TX   = 1;
  localparam int IRQ_LINE = 2;
  localparam int IRQ_ERR  = 3;
  localparam int IRQ_W    = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  localparam logic [2:0] TX_RATE_FAST  = 3'h4;
  localparam logic [2:0] RX_RATE_FAST  = 3'h3;
  localparam logic [1:0] TICK_ENABLED  = 2'h1;
  localparam logic [3:0] DATA_BITS_MAX = 4'h8;
  localparam logic [3:0] SUB_MID       = 4'h7;
  localparam logic [3:0] SUB_LAST      = 4'hF;

  // strap levels: 1 means the strap is on
  typedef struct packed {
    logic [7:0] addr;
    logic [5:0] vec;
    logic [2:0] tx_rate;
    logic [2:0] rx_rate;
    logic       brk;
    logic       par_sense;
    logic [1:0] len;
    logic       stop;
    logic       par_on;
    logic       err_rep;
    logic [1:0] tick;
  } slsc_strap_t;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} slsc_line_state_t;
endpackage

// >>> slsc_tx.sv
// serial transmitter: one start bit, data lsb first, optional parity, stop bits
`timescale 1ns/10ps
module slsc_tx (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       tick_in,
  input  wire logic       start_in,
  input  wire logic [7:0] data_in,
  input  wire logic [3:0] nbits_in,
  input  wire logic       par_en_in,
  input  wire logic       par_odd_in,
  input  wire logic       two_stop_in,
  input  wire logic       brk_in,
  output logic            busy_out,
  output logic            txd_out
);
  import slsc_pkg::*;
  typedef struct packed {
    slsc_line_state_t st;
    logic [3:0] sub;
    logic [3:0] idx;
    logic [7:0] sh;
    logic par;
    logic two;
    logic line;
  } slsc_tx_reg_t;
  slsc_tx_reg_t q, n;

  always_comb begin
    n = q;
    if (srst_in) begin
      n = '0;
      n.st = ST_IDLE;
      n.line = 1'b1;
    end else if (q.st == ST_IDLE) begin
      n.line = ~brk_in; // break only shows between characters
      if (start_in) begin
        n.st = ST_START;
        n.line = 1'b0;
        n.sh = data_in;
        n.par = par_odd_in;
        n.sub = 4'h0;
        n.idx = 4'h0;
        n.two = two_stop_in;
      end
    end else if (tick_in) begin
      n.sub = q.sub + 4'h1;
      if (q.sub == SUB_LAST) begin
        case (q.st)
          ST_START, ST_DATA: begin
            if (q.st == ST_DATA && q.idx == nbits_in) begin
              n.st = par_en_in ? ST_PAR : ST_STOP;
              n.line = par_en_in ? q.par : 1'b1;
            end else begin
              n.st = ST_DATA;
              n.line = q.sh[0];
              n.par = q.par ^ q.sh[0];
              n.sh = {1'b0, q.sh[7:1]};
              n.idx = q.idx + 4'h1;
            end
          end
          ST_PAR: begin
            n.st = ST_STOP;
            n.line = 1'b1;
          end
          ST_STOP: begin
            if (q.two) n.two = 1'b0;
            else n.st = ST_IDLE;
          end
          default: n.st = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= n;
  end

  assign busy_out = (q.st != ST_IDLE);
  assign txd_out  = q.line;

  property p_start_low; @(posedge mclk_in) disable iff (srst_in)
    (q.st == ST_START) |-> !txd_out; endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");
  property p_stop_high; @(posedge mclk_in) disable iff (srst_in)
    (q.st == ST_STOP) |-> txd_out; endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
  property p_two_stop; @(posedge mclk_in) disable iff (srst_in)
    (q.st == ST_START && $past(q.st) == ST_IDLE) |-> q.two == $past(two_stop_in);
  endproperty
  a_two_stop: assert property (p_two_stop) else $error("stop count not latched");
endmodule // slsc_tx

// >>> slsc_rx.sv
// serial receiver: 16x oversampled, mid-bit sampling, parity and framing check
`timescale 1ns/10ps
module slsc_rx (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       tick_in,
  input  wire logic       rxd_in,
  input  wire logic [3:0] nbits_in,
  input  wire logic       par_en_in,
  input  wire logic       par_odd_in,
  output logic            done_out,
  output logic [7:0]      data_out,
  output logic            perr_out,
  output logic            ferr_out
);
  import slsc_pkg::*;
  typedef struct packed {
    slsc_line_state_t st;
    logic [3:0] sub;
    logic [3:0] idx;
    logic [7:0] sh;
    logic par;
    logic perr_acc;
    logic done;
    logic [7:0] data;
    logic perr;
    logic ferr;
  } slsc_rx_reg_t;
  slsc_rx_reg_t q, n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    if (srst_in) begin
      n = '0;
      n.st = ST_IDLE;
    end else if (q.st == ST_IDLE) begin
      if (!rxd_in) begin
        n.st = ST_START;
        n.sub = 4'h0;
      end
    end else if (tick_in) begin
      n.sub = q.sub + 4'h1;
      case (q.st)
        ST_START: if (q.sub == SUB_MID) begin
          n.sub = 4'h0;
          n.idx = 4'h0;
          n.par = par_odd_in;
          n.perr_acc = 1'b0;
          n.st = rxd_in ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (q.sub == SUB_LAST) begin
          n.sh = {rxd_in, q.sh[7:1]};
          n.par = q.par ^ rxd_in;
          n.idx = q.idx + 4'h1;
          if (q.idx + 4'h1 == nbits_in) n.st = par_en_in ? ST_PAR : ST_STOP;
        end
        ST_PAR: if (q.sub == SUB_LAST) begin
          n.perr_acc = (rxd_in != q.par);
          n.st = ST_STOP;
        end
        ST_STOP: if (q.sub == SUB_LAST) begin
          n.done = 1'b1;
          n.ferr = ~rxd_in;
          n.perr = q.perr_acc;
          n.data = q.sh >> (DATA_BITS_MAX - nbits_in);
          n.st = ST_IDLE;
        end
        default: n.st = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= n;
  end

  assign done_out = q.done;
  assign data_out = q.data;
  assign perr_out = q.perr;
  assign ferr_out = q.ferr;

  property p_no_par; @(posedge mclk_in) disable iff (srst_in)
    (q.st == ST_PAR) |-> par_en_in; endproperty
  a_no_par: assert property (p_no_par) else $error("parity slot without parity");
endmodule // slsc_rx

// >>> slsc_top.sv
// strap-configured serial line unit with line clock, Avalon-MM register slave
`timescale 1ns/10ps
module slsc_top #(
  parameter int DIV_SLOW_P = slsc_pkg::DIV_SLOW,
  parameter int DIV_FAST_P = slsc_pkg::DIV_FAST
) (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic [17:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [15:0] avs_writedata_in,
  input  wire logic [1:0]  avs_byteenable_in,
  output logic [15:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             irq_out,
  output logic [15:0]      irq_vector_out,
  output logic             line_clock_active_out,
  input  wire logic        rxd_in,
  output logic             txd_out,
  input  wire logic        line_freq_in,
  input  wire logic [7:0]  addr_strap_in,
  input  wire logic [5:0]  vector_strap_in,
  input  wire logic        tx_rate_strap_a_in,
  input  wire logic        tx_rate_strap_b_in,
  input  wire logic        tx_rate_strap_c_in,
  input  wire logic        rx_rate_strap_a_in,
  input  wire logic        rx_rate_strap_b_in,
  input  wire logic        rx_rate_strap_c_in,
  input  wire logic        break_allow_strap_in,
  input  wire logic        parity_sense_strap_in,
  input  wire logic        char_length_strap_a_in,
  input  wire logic        char_length_strap_b_in,
  input  wire logic        stop_count_strap_in,
  input  wire logic        parity_on_strap_in,
  input  wire logic        error_report_strap_in,
  input  wire logic        line_tick_strap_a_in,
  input  wire logic        line_tick_strap_b_in
);
  import slsc_pkg::*;

  typedef struct packed {
    slsc_strap_t s1;
    slsc_strap_t s2;
    logic        rxd1;
    logic        rxd2;
    logic        lf1;
    logic        lf2;
    logic        lf_prev;
    logic [15:0] txc;
    logic [15:0] rxc;
    logic        tick_tx;
    logic        tick_rx;
    logic        ack;
    logic [15:0] rdata;
    logic        rd_clr;
    logic        rx_done;
    logic        rx_ovr;
    logic        rx_ferr;
    logic        rx_perr;
    logic [7:0]  rx_data;
    logic        tx_break;
    logic        tx_start;
    logic [7:0]  tx_data;
    logic        tx_busy_d;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
  } slsc_top_reg_t;

  slsc_top_reg_t q, n;
  slsc_strap_t   strap_raw;
  logic [17:0]   base;
  logic          dev_hit;
  logic          own_hit;
  logic [1:0]    idx;
  logic          req;
  logic          line_active;
  logic          tx_fast;
  logic          rx_fast;
  logic [15:0]   tx_reload;
  logic [15:0]   rx_reload;
  logic [3:0]    nbits;
  logic          tx_busy;
  logic          tx_ready;
  logic          brk_eff;
  logic          rx_done_p;
  logic [7:0]    rx_byte;
  logic          rx_perr_p;
  logic          rx_ferr_p;
  logic [15:0]   rd_mux;
  logic [IRQ_W-1:0] irq_ev;
  logic          line_edge;

  // strap pins gathered into one struct so both sync stages share a type
  always_comb begin
    strap_raw.addr      = addr_strap_in;
    strap_raw.vec       = vector_strap_in;
    strap_raw.tx_rate   = {tx_rate_strap_a_in, tx_rate_strap_b_in, tx_rate_strap_c_in};
    strap_raw.rx_rate   = {rx_rate_strap_a_in, rx_rate_strap_b_in, rx_rate_strap_c_in};
    strap_raw.brk       = break_allow_strap_in;
    strap_raw.par_sense = parity_sense_strap_in;
    strap_raw.len       = {char_length_strap_b_in, char_length_strap_a_in};
    strap_raw.stop      = stop_count_strap_in;
    strap_raw.par_on    = parity_on_strap_in;
    strap_raw.err_rep   = error_report_strap_in;
    strap_raw.tick      = {line_tick_strap_a_in, line_tick_strap_b_in};
  end

  // a strap that is on pulls its address bit to 0
  assign base = {ADDR_FIXED, ~q.s2.addr, 3'h0};
  assign req = avs_read_in | avs_write_in;
  assign idx = avs_address_in[2:1];
  assign dev_hit = (avs_address_in[17:3] == base[17:3]);
  // if the straps move the base onto the own block, the serial registers win
  assign own_hit = !dev_hit && (avs_address_in[17:3] == OWN_BASE[17:3]);

  assign line_active = (q.s2.tick == TICK_ENABLED) && (base == BASE_DEFAULT);
  // line frequency is slow, so one edge detect after the sync suffices
  assign line_edge = q.lf2 && !q.lf_prev;

  // unrecognised rate patterns fall back to 110 baud
  assign tx_fast = (q.s2.tx_rate == TX_RATE_FAST);
  assign rx_fast = (q.s2.rx_rate == RX_RATE_FAST);
  assign tx_reload = tx_fast ? 16'(DIV_FAST_P - 1) : 16'(DIV_SLOW_P - 1);
  assign rx_reload = rx_fast ? 16'(DIV_FAST_P - 1) : 16'(DIV_SLOW_P - 1);

  // each length strap step removes data bits, counting down from eight
  assign nbits = DATA_BITS_MAX - {2'b00, q.s2.len};
  assign brk_eff = q.tx_break && q.s2.brk;
  // a queued start counts as busy, so a second write cannot overrun it
  assign tx_ready = !tx_busy && !q.tx_start;

  always_comb begin
    // unmapped offsets read as zero
    rd_mux = 16'h0000;
    if (dev_hit) begin
      case (idx)
        REG_RX_STAT: rd_mux[RX_DONE_BIT] = q.rx_done;
        REG_RX_DATA: begin
          rd_mux[7:0] = q.rx_data;
          if (q.s2.err_rep) begin
            rd_mux[15:12] = {q.rx_ovr | q.rx_ferr | q.rx_perr, q.rx_ovr, q.rx_ferr, q.rx_perr};
          end
        end
        REG_TX_STAT: begin
          rd_mux[TX_READY_BIT] = tx_ready;
          rd_mux[TX_BREAK_BIT] = q.tx_break;
        end
        default: rd_mux = 16'h0000;
      endcase
    end else if (own_hit) begin
      case (idx)
        REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = q.irq_stat;
        REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = q.irq_mask;
        REG_LINE:     rd_mux[LINE_ACT_BIT] = line_active;
        default:      rd_mux = 16'h0000;
      endcase
    end
  end

  always_comb begin
    // one-cycle event pulses; the sticky status bits keep them
    irq_ev = '0;
    irq_ev[IRQ_RX] = rx_done_p;
    irq_ev[IRQ_TX] = q.tx_busy_d && !tx_busy;
    irq_ev[IRQ_LINE] = line_edge && line_active;
    irq_ev[IRQ_ERR] = rx_done_p && (rx_perr_p || rx_ferr_p || q.rx_done);
  end

  always_comb begin
    n = q;
    // every strap and the rxd and line frequency pins pass two flops before any decode reads them; bus pins are decoded directly
    n.s1 = strap_raw;
    n.s2 = q.s1;
    n.rxd1 = rxd_in;
    n.rxd2 = q.rxd1;
    n.lf1 = line_freq_in;
    n.lf2 = q.lf1;
    n.lf_prev = q.lf2;
    n.tx_busy_d = tx_busy;
    n.tx_start = 1'b0;
    // free-running dividers: a start is not tick aligned, so its first bit
    // may run one tick short; cheaper than restarting the divider
    n.tick_tx = (q.txc == 16'h0000);
    n.tick_rx = (q.rxc == 16'h0000);
    n.txc = n.tick_tx ? tx_reload : q.txc - 16'h0001;
    n.rxc = n.tick_rx ? rx_reload : q.rxc - 16'h0001;
    // the request is held by the master, so one wait cycle suffices
    n.ack = req && !q.ack;
    if (req && !q.ack) begin
      n.rdata = avs_read_in ? rd_mux : 16'h0000;
      n.rd_clr = avs_read_in && dev_hit && (idx == REG_RX_DATA);
    end
    // the clear lands on the accepting edge; a new character then wins
    if (q.rd_clr && req && q.ack) begin
      n.rx_done = 1'b0;
      n.rd_clr = 1'b0;
    end
    // writes act only on the edge that sees waitrequest low
    if (avs_write_in && q.ack && avs_byteenable_in[0]) begin
      if (dev_hit && idx == REG_TX_STAT) n.tx_break = avs_writedata_in[TX_BREAK_BIT];
      if (dev_hit && idx == REG_TX_DATA && tx_ready) begin
        n.tx_data = avs_writedata_in[7:0];
        n.tx_start = 1'b1;
      end
      if (own_hit && idx == REG_IRQ_MASK) n.irq_mask = avs_writedata_in[IRQ_W-1:0];
    end
    // set wins over the write-one clear
    n.irq_stat = q.irq_stat;
    if (avs_write_in && q.ack && avs_byteenable_in[0] && own_hit && idx == REG_IRQ_STAT) begin
      n.irq_stat = q.irq_stat & ~avs_writedata_in[IRQ_W-1:0];
    end
    n.irq_stat = n.irq_stat | irq_ev;
    // an unread character is replaced and reported as overrun
    if (rx_done_p) begin
      n.rx_ovr = q.rx_done;
      n.rx_done = 1'b1;
      n.rx_data = rx_byte;
      n.rx_perr = rx_perr_p;
      n.rx_ferr = rx_ferr_p;
    end
    // reset last so it overrides every update; the rx sync idles high
    if (srst_in) begin
      n = '0;
      n.rxd1 = 1'b1;
      n.rxd2 = 1'b1;
      n.irq_mask = IRQ_MASK_RST;
    end
  end

  always_ff @(posedge mclk_in) begin
    q <= n;
  end

  // both line engines share the length and parity straps
  slsc_tx u_tx (
    .mclk_in     (mclk_in),
    .srst_in     (srst_in),
    .tick_in     (q.tick_tx),
    .start_in    (q.tx_start),
    .data_in     (q.tx_data),
    .nbits_in    (nbits),
    .par_en_in   (q.s2.par_on),
    .par_odd_in  (q.s2.par_sense),
    .two_stop_in (!q.s2.stop),
    .brk_in      (brk_eff),
    .busy_out    (tx_busy),
    .txd_out     (txd_out)
  );

  slsc_rx u_rx (
    .mclk_in    (mclk_in),
    .srst_in    (srst_in),
    .tick_in    (q.tick_rx),
    .rxd_in     (q.rxd2),
    .nbits_in   (nbits),
    .par_en_in  (q.s2.par_on),
    .par_odd_in (q.s2.par_sense),
    .done_out   (rx_done_p),
    .data_out   (rx_byte),
    .perr_out   (rx_perr_p),
    .ferr_out   (rx_ferr_p)
  );

  assign avs_readdata_out = q.rdata;
  assign avs_waitrequest_out = req && !q.ack;
  assign irq_out = |(q.irq_stat & q.irq_mask);
  assign irq_vector_out = {VEC_FIXED_HI, q.s2.vec, VEC_FIXED_LO};
  assign line_clock_active_out = line_active;

  // bus and decode checks
  property p_tx_go; @(posedge mclk_in) disable iff (srst_in)
    (avs_write_in && q.ack && dev_hit && idx == REG_TX_DATA && tx_ready && avs_byteenable_in[0])
    |-> ##[1:2] tx_busy; endproperty
  a_tx_go: assert property (p_tx_go) else $error("data write did not start transmit");
  property p_top_page; @(posedge mclk_in) disable iff (srst_in)
    (avs_write_in && !avs_address_in[17]) |=> !q.tx_start; endproperty
  a_top_page: assert property (p_top_page) else $error("access outside top page selected");
  property p_unmapped; @(posedge mclk_in) disable iff (srst_in)
    (avs_read_in && !dev_hit && !own_hit && !q.ack) |=> avs_readdata_out == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // strap decode checks and the bus answer check
  property p_vec; @(posedge mclk_in) disable iff (srst_in)
    irq_vector_out[2:0] == 3'h0 && irq_vector_out[15:9] == 7'h00; endproperty
  a_vec: assert property (p_vec) else $error("fixed vector bits wrong");
  property p_line_gate; @(posedge mclk_in) disable iff (srst_in)
    $rose(q.irq_stat[IRQ_LINE]) |-> $past(base) == BASE_DEFAULT; endproperty
  a_line_gate: assert property (p_line_gate) else $error("line tick at other base");
  property p_line_straps; @(posedge mclk_in) disable iff (srst_in)
    line_clock_active_out |-> !q.s2.tick[1] && q.s2.tick[0]; endproperty
  a_line_straps: assert property (p_line_straps) else $error("line clock wrong straps");
  property p_rate; @(posedge mclk_in) disable iff (srst_in)
    (q.tick_tx && $past(tx_fast)) |-> q.txc == 16'(DIV_FAST_P - 1); endproperty
  a_rate: assert property (p_rate) else $error("tx divider wrong for fast rate");
  property p_no_break; @(posedge mclk_in) disable iff (srst_in)
    (!q.s2.brk && $past(!q.s2.brk) && !tx_busy && $past(!tx_busy)) |-> txd_out; endproperty
  a_no_break: assert property (p_no_break) else $error("break sent while disallowed");
  property p_len8; @(posedge mclk_in) disable iff (srst_in)
    (q.s2.len == 2'h0) |-> nbits == 4'h8; endproperty
  a_len8: assert property (p_len8) else $error("default length not eight");
  property p_err_hide; @(posedge mclk_in) disable iff (srst_in)
    (avs_read_in && dev_hit && idx == REG_RX_DATA && !q.ack && !q.s2.err_rep)
    |=> avs_readdata_out[15:12] == 4'h0; endproperty
  a_err_hide: assert property (p_err_hide) else $error("error bits shown while off");
  property p_answer; @(posedge mclk_in) disable iff (srst_in)
    (req && !q.ack) |=> !avs_waitrequest_out; endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait cycle");

  property p_hit_page; @(posedge mclk_in) disable iff (srst_in)
    (dev_hit || own_hit) |-> (&avs_address_in[17:11]); endproperty
  a_hit_page: assert property (p_hit_page) else $error("selected outside top page");

  property p_rx_clear; @(posedge mclk_in) disable iff (srst_in)
    (q.rd_clr && avs_read_in && q.ack && !rx_done_p) |=> !q.rx_done; endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("data read left rx done set");

  property p_tick_off; @(posedge mclk_in) disable iff (srst_in)
    irq_ev[IRQ_LINE] |-> q.s2.tick == TICK_ENABLED; endproperty
  a_tick_off: assert property (p_tick_off) else $error("line tick while disabled");

  property p_one_wait; @(posedge mclk_in) disable iff (srst_in)
    q.ack |=> !q.ack; endproperty
  a_one_wait: assert property (p_one_wait) else $error("acknowledge held two cycles");

  c_rx: cover property (@(posedge mclk_in) disable iff (srst_in) rx_done_p);
  c_tx: cover property (@(posedge mclk_in) disable iff (srst_in) irq_ev[IRQ_TX]);
  c_line: cover property (@(posedge mclk_in) disable iff (srst_in) irq_ev[IRQ_LINE]);
  c_irq: cover property (@(posedge mclk_in) disable iff (srst_in) $rose(irq_out));
  c_break: cover property (@(posedge mclk_in) disable iff (srst_in) brk_eff && !tx_busy);
endmodule // slsc_top

// >>> slsc_term.sv
// serial terminal model on the far side of the line
`timescale 1ns/10ps
module slsc_term (
  input  wire logic mclk_in,
  input  wire logic txd_in,
  output logic      rxd_out
);
  initial rxd_out = 1'b1;
  task automatic put(input logic b, input int bc);
    rxd_out <= b;
    repeat (bc) @(posedge mclk_in);
  endtask
  // bad flips the parity bit on purpose
  task automatic send(input logic [7:0] d, input int n, input logic pe, input logic od,
                      input logic bad, input int bc);
    put(1'b0, bc);
    for (int i = 0; i < n; i++) put(d[i], bc);
    if (pe) put((^(d & (8'hFF >> (8 - n)))) ^ od ^ bad, bc);
    put(1'b1, bc);
  endtask
  // mid-bit sampling; returns at the middle of the first stop bit
  task automatic recv(output logic [7:0] d, output logic p, output logic sb, input int n,
                      input logic pe, input int bc);
    int w;
    w = 0;
    d = 8'h00;
    p = 1'b0;
    while (txd_in !== 1'b0 && w < 5000) begin
      @(posedge mclk_in);
      w++;
    end
    repeat (bc / 2) @(posedge mclk_in);
    for (int i = 0; i < n; i++) begin
      repeat (bc) @(posedge mclk_in);
      d[i] = txd_in;
    end
    if (pe) begin
      repeat (bc) @(posedge mclk_in);
      p = txd_in;
    end
    repeat (bc) @(posedge mclk_in);
    sb = txd_in;
  endtask
endmodule // slsc_term

// >>> slsc_top_tb.sv
// self-checking bench for the strap-configured serial line unit
`timescale 1ns/10ps
module slsc_top_tb;
  import slsc_pkg::*;
  // bit lengths with the shortened dividers: 16 ticks of 4 or 2 clocks
  localparam int BS = 64;
  localparam int BF = 32;
  localparam logic [17:0] BASE = {7'h7F, ~8'h11, 3'h0};
  logic        mclk_in, srst_in, rd, wr, lf, rxd, txd, irq, lact, wq, p, sb;
  logic [17:0] adr;
  logic [15:0] wdat, rdat, vec, q;
  logic [7:0]  d;
  slsc_strap_t s, dflt;
  int          n_fail, n_tests;
  slsc_top #(.DIV_SLOW_P(4), .DIV_FAST_P(2)) uut (
    .mclk_in(mclk_in), .srst_in(srst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(2'h3),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wq), .irq_out(irq),
    .irq_vector_out(vec), .line_clock_active_out(lact), .rxd_in(rxd), .txd_out(txd),
    .line_freq_in(lf), .addr_strap_in(s.addr), .vector_strap_in(s.vec),
    .tx_rate_strap_a_in(s.tx_rate[2]), .tx_rate_strap_b_in(s.tx_rate[1]),
    .tx_rate_strap_c_in(s.tx_rate[0]), .rx_rate_strap_a_in(s.rx_rate[2]),
    .rx_rate_strap_b_in(s.rx_rate[1]), .rx_rate_strap_c_in(s.rx_rate[0]),
    .break_allow_strap_in(s.brk), .parity_sense_strap_in(s.par_sense),
    .char_length_strap_a_in(s.len[0]), .char_length_strap_b_in(s.len[1]),
    .stop_count_strap_in(s.stop), .parity_on_strap_in(s.par_on),
    .error_report_strap_in(s.err_rep), .line_tick_strap_a_in(s.tick[1]),
    .line_tick_strap_b_in(s.tick[0]));
  slsc_term term (.mclk_in(mclk_in), .txd_in(txd), .rxd_out(rxd));
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h", $time, m, got);
    end
  endtask
  // request held until an edge that sees waitrequest low
  task automatic bus(input logic w, input logic [17:0] a, input logic [15:0] x);
    @(posedge mclk_in);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= x;
    do @(posedge mclk_in); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [17:0] a, input logic [15:0] e, input string m);
    bus(1'b0, a, 16'h0000);
    chk(q, e, m);
  endtask
  task automatic nedge(input int n);
    repeat (n) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  // straps pass two flops, so allow a few edges to settle
  task automatic st(input slsc_strap_t v);
    @(posedge mclk_in);
    s <= v;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic tick;
    @(posedge mclk_in);
    lf <= 1'b1;
    repeat (8) @(posedge mclk_in);
    lf <= 1'b0;
    repeat (8) @(posedge mclk_in);
  endtask
  task automatic t_ident;
    slsc_strap_t v;
    v = dflt;
    nedge(0);
    chk({14'h0, txd, irq}, 16'h0002, "reset pins");
    chk(vec, 16'h0030, "vector");
    chk({15'h0, lact}, 16'h0001, "line on");
    rchk(OWN_BASE + 18'h2, 16'h0000, "mask reset");
    v.vec = 6'h29;
    v.tick = 2'h3;
    st(v);
    nedge(1);
    chk(vec, 16'h0148, "vector strap");
    chk({15'h0, lact}, 16'h0000, "line straps");
    v = dflt;
    v.addr = 8'h01;
    st(v);
    nedge(1);
    chk({15'h0, lact}, 16'h0000, "line moved");
    rchk({7'h7F, ~v.addr, 3'h4}, 16'h0080, "moved base");
    rchk(BASE + 18'h4, 16'h0000, "old base");
    st(dflt);
    rchk(BASE + 18'h4, 16'h0080, "tx ready");
    rchk(BASE + 18'h4 - 18'h20000, 16'h0000, "low page");
    $display("ident and address test done");
  endtask
  task automatic t_tx;
    slsc_strap_t v;
    bus(1'b1, BASE + 18'h6, 16'h00A5);
    term.recv(d, p, sb, 8, 1'b0, BS);
    chk({7'h0, sb, d}, 16'h01A5, "tx frame");
    repeat (BS * 3 / 4) @(posedge mclk_in);
    rchk(BASE + 18'h4, 16'h0000, "second stop");
    repeat (2 * BS) @(posedge mclk_in);
    v = dflt;
    v.tx_rate = 3'h4;
    v.par_on = 1'b1;
    v.par_sense = 1'b1;
    v.len = 2'h1;
    v.stop = 1'b1;
    st(v);
    bus(1'b1, BASE + 18'h6, 16'h0035);
    term.recv(d, p, sb, 7, 1'b1, BF);
    chk({6'h0, sb, p, d}, 16'h0335, "fast odd frame");
    repeat (BF * 3 / 4) @(posedge mclk_in);
    rchk(BASE + 18'h4, 16'h0080, "one stop");
    st(dflt);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    slsc_strap_t v;
    v = dflt;
    term.send(8'h5A, 8, 1'b0, 1'b0, 1'b0, BS);
    rchk(BASE, 16'h0080, "rx done");
    rchk(BASE + 18'h2, 16'h005A, "rx data");
    rchk(BASE, 16'h0000, "done cleared");
    v.rx_rate = 3'h3;
    v.par_on = 1'b1;
    st(v);
    term.send(8'hC3, 8, 1'b1, 1'b0, 1'b1, BF);
    rchk(BASE + 18'h2, 16'h00C3, "err withheld");
    v.err_rep = 1'b1;
    st(v);
    term.send(8'hC3, 8, 1'b1, 1'b0, 1'b1, BF);
    rchk(BASE + 18'h2, 16'h90C3, "err shown");
    term.send(8'h81, 8, 1'b1, 1'b0, 1'b0, BF);
    rchk(BASE + 18'h2, 16'h0081, "even ok");
    st(dflt);
    $display("receive test done");
  endtask
  task automatic t_irq;
    slsc_strap_t v;
    v = dflt;
    bus(1'b1, OWN_BASE, 16'h000F);
    rchk(OWN_BASE, 16'h0000, "irq clear");
    term.send(8'h3C, 8, 1'b0, 1'b0, 1'b0, BS);
    nedge(1);
    chk({15'h0, irq}, 16'h0000, "masked");
    bus(1'b1, OWN_BASE + 18'h2, 16'h0001);
    nedge(1);
    chk({15'h0, irq}, 16'h0001, "unmasked");
    bus(1'b1, OWN_BASE, 16'h0001);
    nedge(1);
    chk({15'h0, irq}, 16'h0000, "w1c");
    rchk(OWN_BASE + 18'h4, 16'h0001, "active reg");
    tick;
    rchk(OWN_BASE, 16'h0004, "tick");
    v.tick = 2'h0;
    st(v);
    bus(1'b1, OWN_BASE, 16'h000F);
    tick;
    rchk(OWN_BASE, 16'h0000, "no tick");
    st(dflt);
    $display("interrupt test done");
  endtask
  task automatic t_brk;
    slsc_strap_t v;
    v = dflt;
    bus(1'b1, BASE + 18'h4, 16'h0001);
    nedge(4);
    chk({15'h0, txd}, 16'h0001, "break blocked");
    v.brk = 1'b1;
    st(v);
    nedge(1);
    chk({15'h0, txd}, 16'h0000, "break sent");
    bus(1'b1, BASE + 18'h4, 16'h0000);
    nedge(2);
    chk({15'h0, txd}, 16'h0001, "break off");
    $display("break test done");
  endtask
  initial begin
    n_fail = 0;
    n_tests = 0;
    dflt = '{8'h11, 6'h06, 3'h7, 3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h1};
    s = dflt;
    {rd, wr, lf} = 3'h0;
    adr = 18'h00000;
    wdat = 16'h0000;
    srst_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    srst_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    t_ident;
    t_tx;
    t_rx;
    t_irq;
    t_brk;
    print_verdict;
  end
  // the whole sequence needs roughly 4,000 cycles
  initial begin
    #1_000_000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict;
  end
endmodule // slsc_top_tb
